// ### rtl/sbt_defines.svh
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

`define SBT_IR_W        3
`define SBT_IR_EXTEST   3'h0
`define SBT_IR_IDCODE   3'h1
`define SBT_IR_SAMPLEZ  3'h2
`define SBT_IR_PRELOAD  3'h4
`define SBT_IR_BYPASS   3'h7
`define SBT_IR_CAPTURE  2'h1
`define SBT_ID_W        32
`define SBT_ID_FIXED    1'h1
`define SBT_MFR_W       11
`define SBT_ATTR_W      20
`define SBT_PLACEHOLDER 1'h1
`define SBT_PIN_IDLE    1'h1
`define SBT_PIN_COUNT   8
`define SBT_BSR_LEN     12

`endif

// ### rtl/sbt_pkg.sv
`include "sbt_defines.svh"

package sbt_pkg;

    typedef logic [`SBT_IR_W-1:0] sbt_instr_type;

    typedef enum logic [3:0]
    {
        ST_RESET      = 4'hF,
        ST_IDLE       = 4'hC,
        ST_SEL_DR     = 4'h7,
        ST_CAPTURE_DR = 4'h6,
        ST_SHIFT_DR   = 4'h2,
        ST_EXIT1_DR   = 4'h1,
        ST_PAUSE_DR   = 4'h3,
        ST_EXIT2_DR   = 4'h0,
        ST_UPDATE_DR  = 4'h5,
        ST_SEL_IR     = 4'h4,
        ST_CAPTURE_IR = 4'hE,
        ST_SHIFT_IR   = 4'hA,
        ST_EXIT1_IR   = 4'h9,
        ST_PAUSE_IR   = 4'hB,
        ST_EXIT2_IR   = 4'h8,
        ST_UPDATE_IR  = 4'hD
    } sbt_state_type;

    typedef enum logic [1:0]
    {
        SEL_INSTR = 2'h0,
        SEL_PASS  = 2'h1,
        SEL_IDENT = 2'h2,
        SEL_BSCAN = 2'h3
    } sbt_path_type;

endpackage

// ### rtl/sbt_sync.sv
`timescale 1ns/10ps
`include "sbt_defines.svh"

module sbt_sync
#(
    parameter int WIDTH = 3
)
(
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // -------------------------------------------------------------
    // Two-stage synchroniser
    // -------------------------------------------------------------
    // Idle level one stands in for the pad pull-ups
    always_comb
    begin
        next_meta     = reset_n ? async_in : {WIDTH{`SBT_PIN_IDLE}};
        next_sync_out = reset_n ? meta     : {WIDTH{`SBT_PIN_IDLE}};
    end

    always_ff @(posedge mclk)
    begin
        meta     <= next_meta;
        sync_out <= next_sync_out;
    end

endmodule

// ### rtl/sbt_bscan.sv
`timescale 1ns/10ps
`include "sbt_defines.svh"

module sbt_bscan
#(
    parameter int PINS = `SBT_PIN_COUNT,
    parameter int LEN  = `SBT_BSR_LEN
)
(
    input  wire logic            mclk,
    input  wire logic            reset_n,
    input  wire logic            capture_en,
    input  wire logic            shift_en,
    input  wire logic            update_en,
    input  wire logic            serial_in,
    input  wire logic [PINS-1:0] pin_levels,
    output logic                 serial_out,
    output logic      [PINS-1:0] parallel_out
);

    logic [LEN-1:0]  cells;
    logic [LEN-1:0]  next_cells;
    logic [PINS-1:0] next_parallel_out;

    generate
        if (PINS < 1 || PINS > LEN)
        begin : g_bad
            $error("boundary length must cover all pins");
        end
    endgenerate

    // -------------------------------------------------------------
    // Capture, shift and update stages
    // -------------------------------------------------------------
    always_comb
    begin
        next_cells        = cells;
        next_parallel_out = parallel_out;
        if (!reset_n)
        begin
            next_cells        = {LEN{`SBT_PLACEHOLDER}};
            next_parallel_out = '0;
        end
        else if (capture_en)
        begin
            next_cells             = {LEN{`SBT_PLACEHOLDER}};
            next_cells[PINS-1:0]   = pin_levels;
        end
        else if (shift_en)
        begin
            next_cells = {serial_in, cells[LEN-1:1]};
        end
        else if (update_en)
        begin
            next_parallel_out = cells[PINS-1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        cells        <= next_cells;
        parallel_out <= next_parallel_out;
    end

    assign serial_out = cells[0];

endmodule

// ### rtl/sbt_tap.sv
`timescale 1ns/10ps
`include "sbt_defines.svh"

module sbt_tap
    import sbt_pkg::*;
#(
    parameter int                     PINS      = `SBT_PIN_COUNT,
    parameter int                     BSR_LEN   = `SBT_BSR_LEN,
    // Arbitrary neutral maker and attribute values
    parameter logic [`SBT_MFR_W-1:0]  MFR_CODE  = 11'h2A5,
    parameter logic [`SBT_ATTR_W-1:0] ATTR_CODE = 20'h00C3A
)
(
    input  wire logic            mclk,
    input  wire logic            reset_n,
    input  wire logic            tck,
    input  wire logic            tms,
    input  wire logic            tdi,
    input  wire logic [PINS-1:0] pin_levels,
    output logic                 tdo,
    output logic                 tdo_en,
    output logic                 outputs_hiz,
    output logic                 extest_en,
    output logic      [PINS-1:0] bsr_drive,
    output sbt_pkg::sbt_instr_type active_instr,
    output sbt_pkg::sbt_state_type tap_state
);

    import sbt_pkg::*;

    // -------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------
    function automatic sbt_state_type tap_step
    (
        input sbt_state_type cur,
        input logic          mode
    );
        sbt_state_type nxt;
        nxt = ST_RESET;
        case (cur)
            ST_RESET:      nxt = mode ? ST_RESET    : ST_IDLE;
            ST_IDLE:       nxt = mode ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:     nxt = mode ? ST_SEL_IR   : ST_CAPTURE_DR;
            ST_CAPTURE_DR: nxt = mode ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR:   nxt = mode ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR:   nxt = mode ? ST_UPDATE_DR : ST_PAUSE_DR;
            ST_PAUSE_DR:   nxt = mode ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR:   nxt = mode ? ST_UPDATE_DR : ST_SHIFT_DR;
            ST_UPDATE_DR:  nxt = mode ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:     nxt = mode ? ST_RESET    : ST_CAPTURE_IR;
            ST_CAPTURE_IR: nxt = mode ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR:   nxt = mode ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR:   nxt = mode ? ST_UPDATE_IR : ST_PAUSE_IR;
            ST_PAUSE_IR:   nxt = mode ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR:   nxt = mode ? ST_UPDATE_IR : ST_SHIFT_IR;
            ST_UPDATE_IR:  nxt = mode ? ST_SEL_DR   : ST_IDLE;
            default:       nxt = ST_RESET;
        endcase
        return nxt;
    endfunction

    // Private codes fall back to the pass-through path
    function automatic sbt_path_type path_of
    (
        input sbt_state_type cur,
        input sbt_instr_type ins
    );
        sbt_path_type p;
        p = SEL_PASS;
        if (cur == ST_CAPTURE_IR || cur == ST_SHIFT_IR)
        begin
            p = SEL_INSTR;
        end
        else
        begin
            case (ins)
                `SBT_IR_EXTEST,
                `SBT_IR_SAMPLEZ,
                `SBT_IR_PRELOAD: p = SEL_BSCAN;
                `SBT_IR_IDCODE:  p = SEL_IDENT;
                default:         p = SEL_PASS;
            endcase
        end
        return p;
    endfunction

    // -------------------------------------------------------------
    // Pin sampling and edge finding
    // -------------------------------------------------------------
    logic [2:0] pins_sync;
    logic [PINS-1:0] pin_levels_s;
    logic       tck_s;
    logic       tms_s;
    logic       tdi_s;
    logic       tck_prev;
    logic       next_tck_prev;
    logic       tck_rise;
    logic       tck_fall;

    sbt_sync
    #(
        .WIDTH (3)
    )
    u_sync
    (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .async_in ({tck, tms, tdi}),
        .sync_out (pins_sync)
    );

    // Memory pins get their own synchroniser on the same clock
    sbt_sync
    #(
        .WIDTH (PINS)
    )
    u_pin_sync
    (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .async_in (pin_levels),
        .sync_out (pin_levels_s)
    );

    assign tck_s = pins_sync[2];
    assign tms_s = pins_sync[1];
    assign tdi_s = pins_sync[0];

    // Starts high so a stopped clock never fakes an edge
    always_comb
    begin
        next_tck_prev = reset_n ? tck_s : `SBT_PIN_IDLE;
    end

    always_ff @(posedge mclk)
    begin
        tck_prev <= next_tck_prev;
    end

    assign tck_rise = tck_s & ~tck_prev;
    assign tck_fall = ~tck_s & tck_prev;

    // -------------------------------------------------------------
    // Controller
    // -------------------------------------------------------------
    sbt_state_type next_tap_state;

    always_comb
    begin
        next_tap_state = tap_state;
        if (!reset_n)
        begin
            next_tap_state = ST_RESET;
        end
        else if (tck_rise)
        begin
            next_tap_state = tap_step(tap_state, tms_s);
        end
    end

    // Five high samples reach reset from any state
    always_ff @(posedge mclk)
    begin
        tap_state <= next_tap_state;
    end

    // -------------------------------------------------------------
    // Serial registers
    // -------------------------------------------------------------
    sbt_path_type                path;
    sbt_instr_type               instr_shift;
    sbt_instr_type               next_instr_shift;
    sbt_instr_type               next_active_instr;
    logic                        pass_bit;
    logic                        next_pass_bit;
    logic [`SBT_ID_W-1:0]        id_shift;
    logic [`SBT_ID_W-1:0]        next_id_shift;
    logic [`SBT_ID_W-1:0]        identity_rom;
    logic                        bsr_out;
    logic                        in_shift;
    logic                        bsr_sel;

    assign identity_rom = {ATTR_CODE, MFR_CODE, `SBT_ID_FIXED};
    assign path         = path_of(tap_state, active_instr);
    assign in_shift     = tap_state == ST_SHIFT_IR
                          || tap_state == ST_SHIFT_DR;
    assign bsr_sel      = path == SEL_BSCAN;

    always_comb
    begin
        next_instr_shift  = instr_shift;
        next_active_instr = active_instr;
        next_pass_bit     = pass_bit;
        next_id_shift     = id_shift;
        if (!reset_n || tap_state == ST_RESET)
        begin
            next_instr_shift  = `SBT_IR_IDCODE;
            next_active_instr = `SBT_IR_IDCODE;
            next_pass_bit     = 1'h0;
            next_id_shift     = identity_rom;
        end
        else if (tck_rise)
        begin
            case (tap_state)
                ST_CAPTURE_IR:
                begin
                    next_instr_shift = {instr_shift[`SBT_IR_W-1:2],
                                        `SBT_IR_CAPTURE};
                end
                ST_SHIFT_IR:
                begin
                    next_instr_shift = {tdi_s,
                        instr_shift[`SBT_IR_W-1:1]};
                end
                ST_CAPTURE_DR:
                begin
                    next_pass_bit = 1'h0;
                    if (path == SEL_IDENT)
                    begin
                        next_id_shift = identity_rom;
                    end
                end
                ST_SHIFT_DR:
                begin
                    if (path == SEL_PASS)
                    begin
                        next_pass_bit = tdi_s;
                    end
                    if (path == SEL_IDENT)
                    begin
                        next_id_shift = {tdi_s,
                            id_shift[`SBT_ID_W-1:1]};
                    end
                end
                default:
                begin
                    next_pass_bit = pass_bit;
                end
            endcase
        end
        else if (tck_fall && tap_state == ST_UPDATE_IR)
        begin
            next_active_instr = instr_shift;
        end
    end

    always_ff @(posedge mclk)
    begin
        instr_shift  <= next_instr_shift;
        active_instr <= next_active_instr;
        pass_bit     <= next_pass_bit;
        id_shift     <= next_id_shift;
    end

    sbt_bscan
    #(
        .PINS (PINS),
        .LEN  (BSR_LEN)
    )
    u_bscan
    (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .capture_en   (tck_rise && bsr_sel
                       && tap_state == ST_CAPTURE_DR),
        .shift_en     (tck_rise && bsr_sel
                       && tap_state == ST_SHIFT_DR),
        .update_en    (tck_fall && bsr_sel
                       && tap_state == ST_UPDATE_DR),
        .serial_in    (tdi_s),
        .pin_levels   (pin_levels_s),
        .serial_out   (bsr_out),
        .parallel_out (bsr_drive)
    );

    // -------------------------------------------------------------
    // Serial output and memory-side controls
    // -------------------------------------------------------------
    logic next_tdo;
    logic next_tdo_en;
    logic next_outputs_hiz;
    logic next_extest_en;

    always_comb
    begin
        next_tdo         = tdo;
        next_tdo_en      = tdo_en;
        next_outputs_hiz = active_instr == `SBT_IR_SAMPLEZ;
        next_extest_en   = active_instr == `SBT_IR_EXTEST;
        if (!reset_n)
        begin
            next_tdo         = 1'h0;
            next_tdo_en      = 1'h0;
            next_outputs_hiz = 1'h0;
            next_extest_en   = 1'h0;
        end
        else if (tck_fall)
        begin
            next_tdo_en = in_shift;
            case (path)
                SEL_INSTR: next_tdo = instr_shift[0];
                SEL_IDENT: next_tdo = id_shift[0];
                SEL_BSCAN: next_tdo = bsr_out;
                SEL_PASS:  next_tdo = pass_bit;
                default:   next_tdo = pass_bit;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        tdo         <= next_tdo;
        tdo_en      <= next_tdo_en;
        outputs_hiz <= next_outputs_hiz;
        extest_en   <= next_extest_en;
    end

endmodule

// ### verif/sbt_tap_checker.sv
`timescale 1ns/10ps
`include "sbt_defines.svh"

module sbt_tap_checker
    import sbt_pkg::*;
(
    input wire logic               mclk,
    input wire logic               reset_n,
    input wire logic               tck,
    input wire logic               tms,
    input wire logic               tdo,
    input wire logic               tdo_en,
    input wire logic               outputs_hiz,
    input wire logic               extest_en,
    input sbt_pkg::sbt_instr_type  active_instr,
    input sbt_pkg::sbt_state_type  tap_state
);
    import sbt_pkg::*;

    // --------
    // Edge ages
    // --------
    logic       tck_q, next_tck_q;
    logic [7:0] rise_age, next_rise_age;
    logic [7:0] fall_age, next_fall_age;
    logic [2:0] ones, next_ones;

    // Ages saturate so a parked clock never wraps into a false window
    always_comb
    begin
        next_tck_q    = tck;
        next_rise_age = rise_age + {7'h00, rise_age != 8'hFF};
        next_fall_age = fall_age + {7'h00, fall_age != 8'hFF};
        next_ones     = ones;
        if (tck && !tck_q)
        begin
            next_rise_age = 8'h00;
            next_ones     = tms ? ones + {2'h0, ones != 3'h7} : 3'h0;
        end
        if (!tck && tck_q)
            next_fall_age = 8'h00;
    end

    always_ff @(posedge mclk)
    begin
        tck_q    <= reset_n ? next_tck_q : 1'h1;
        rise_age <= reset_n ? next_rise_age : 8'hFF;
        fall_age <= reset_n ? next_fall_age : 8'hFF;
        ones     <= reset_n ? next_ones : 3'h0;
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_reset_instr;
        $rose(reset_n) |-> active_instr == `SBT_IR_IDCODE
            && tap_state == ST_RESET;
    endproperty
    a_reset_instr: assert property (p_reset_instr)
        else $error("Instruction not preset after reset");

    property p_state_on_rise;
        !$stable(tap_state) |-> rise_age <= 8'h08;
    endproperty
    a_state_on_rise: assert property (p_state_on_rise)
        else $error("State moved without a test clock rise");

    property p_out_on_fall;
        !$stable(tdo) || !$stable(tdo_en) |-> fall_age <= 8'h08;
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("Serial output moved without a falling edge");

    property p_en_states;
        tdo_en |-> tap_state inside
            {ST_SHIFT_DR, ST_SHIFT_IR, ST_EXIT1_DR, ST_EXIT1_IR};
    endproperty
    a_en_states: assert property (p_en_states)
        else $error("Serial output driven outside shifting");

    property p_en_rise;
        $rose(tdo_en) |-> tap_state inside {ST_SHIFT_DR, ST_SHIFT_IR};
    endproperty
    a_en_rise: assert property (p_en_rise)
        else $error("Serial output enabled outside shift state");

    property p_tlr_instr;
        (tap_state == ST_RESET) [*2] |-> active_instr == `SBT_IR_IDCODE;
    endproperty
    a_tlr_instr: assert property (p_tlr_instr)
        else $error("Reset state lost the identification instruction");

    property p_instr_update;
        !$stable(active_instr) |-> tap_state == ST_RESET
            || (tap_state == ST_UPDATE_IR && fall_age <= 8'h08);
    endproperty
    a_instr_update: assert property (p_instr_update)
        else $error("Instruction changed outside update");

    property p_hiz;
        $stable(active_instr) |->
            outputs_hiz == (active_instr == `SBT_IR_SAMPLEZ);
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("High-Z flag disagrees with instruction");

    property p_extest;
        $stable(active_instr) |->
            extest_en == (active_instr == `SBT_IR_EXTEST);
    endproperty
    a_extest: assert property (p_extest)
        else $error("External test flag disagrees with instruction");

    property p_five_ones;
        $rose(ones == 3'h5) |-> ##[0:8] tap_state == ST_RESET;
    endproperty
    a_five_ones: assert property (p_five_ones)
        else $error("Five high mode samples did not reset");

    c_shift_dr: cover property (tap_state == ST_SHIFT_DR);
    c_hiz: cover property (outputs_hiz);
    c_five: cover property ($rose(ones == 3'h5));
endmodule

bind sbt_tap sbt_tap_checker u_chk
(
    .mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdo(tdo),
    .tdo_en(tdo_en), .outputs_hiz(outputs_hiz), .extest_en(extest_en),
    .active_instr(active_instr), .tap_state(tap_state)
);

// ### verif/sbt_ctl_model.sv
`timescale 1ns/10ps

module sbt_ctl_model
(
    input  wire logic mclk,
    input  wire logic slow,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    // Clock parks high between frames; lines rest at pull-up level
    initial
    begin
        tck = 1'h1;
        tms = 1'h1;
        tdi = 1'h1;
    end

    // Clock toggles every 80 ns (160 ns period); slow mode parks it high between ticks
    task automatic tick(input logic mode, input logic data,
                        output logic seen);
        @(negedge mclk);
        tck <= 1'h0;
        tms <= mode;
        tdi <= data;
        repeat (20) @(negedge mclk);
        seen = tdo;
        tck <= 1'h1;
        repeat (19) @(negedge mclk);
        if (slow)
            repeat (40) @(negedge mclk);
    endtask

    task automatic park();
        @(negedge mclk);
        tms <= 1'h1;
        tdi <= 1'h1;
    endtask
endmodule

// ### verif/tb_sbt_tap.sv
`timescale 1ns/10ps
`include "sbt_defines.svh"

module tb_sbt_tap;
    import sbt_pkg::*;

    // Arbitrary maker and attribute values
    localparam logic [10:0] MFR  = 11'h155;
    localparam logic [19:0] ATTR = 20'h5A0F3;

    logic          mclk;
    logic          reset_n;
    logic          slow;
    logic [7:0]    pin_levels;
    logic          tck, tms, tdi, tdo, tdo_en;
    logic          outputs_hiz, extest_en;
    logic [7:0]    bsr_drive;
    sbt_instr_type active_instr;
    sbt_state_type tap_state;
    logic [31:0]   word;
    logic          o;
    logic [2:0]    prev;
    logic [2:0]    codes [7];
    int            fails;
    int            total_checks;

    sbt_tap #(.MFR_CODE(MFR), .ATTR_CODE(ATTR)) dut
    (
        .mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .pin_levels(pin_levels), .tdo(tdo), .tdo_en(tdo_en),
        .outputs_hiz(outputs_hiz), .extest_en(extest_en),
        .bsr_drive(bsr_drive), .active_instr(active_instr),
        .tap_state(tap_state)
    );

    sbt_ctl_model ctl
    (
        .mclk(mclk), .slow(slow), .tdo(tdo),
        .tck(tck), .tms(tms), .tdi(tdi)
    );

    // --------
    // Tasks
    // --------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // From idle through one scan and back to idle, bits LSB first
    task automatic scan(input logic ir, input logic [31:0] din,
                        input int n, output logic [31:0] dout);
        logic b;
        dout = 32'h0;
        ctl.tick(1'h1, 1'h1, b);
        if (ir)
            ctl.tick(1'h1, 1'h1, b);
        ctl.tick(1'h0, 1'h1, b);
        ctl.tick(1'h0, 1'h1, b);
        for (int i = 0; i < n; i++)
        begin
            ctl.tick(i == n - 1, din[i], b);
            dout[i] = b;
            check("tdo_en", tdo_en, 1'h1);
        end
        ctl.tick(1'h1, 1'h1, b);
        check("tdo_off", tdo_en, 1'h0);
        ctl.tick(1'h0, 1'h1, b);
        ctl.park();
    endtask

    task automatic wrap_up();
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // --------
    // Sequence
    // --------
    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        #200000;
        fails++;
        wrap_up();
    end

    initial
    begin
        fails        = 0;
        total_checks = 0;
        reset_n      = 1'h0;
        slow         = 1'h0;
        pin_levels   = 8'h00;
        prev         = `SBT_IR_IDCODE;
        codes        = '{`SBT_IR_BYPASS, 3'h3, 3'h5, 3'h6, `SBT_IR_PRELOAD,
                         `SBT_IR_SAMPLEZ, `SBT_IR_EXTEST};
        repeat (4) @(negedge mclk);
        reset_n = 1'h1;
        repeat (40) @(negedge mclk);
        check("state", tap_state, ST_RESET);
        check("instr", active_instr, `SBT_IR_IDCODE);
        ctl.tick(1'h0, 1'h1, o);
        scan(1'h0, 32'h0, 32, word);
        check("ident", word, {ATTR, MFR, `SBT_ID_FIXED});
        for (int k = 0; k < 7; k++)
        begin
            slow       = k[0];
            pin_levels = {k[3:0], ~k[3:0]};
            scan(1'h1, {29'h0, codes[k]}, 3, word);
            check("ir_capture", word[2:0], {prev[2], 2'h1});
            check("instr", active_instr, codes[k]);
            prev = codes[k];
            repeat (4) @(negedge mclk);
            check("hiz", outputs_hiz, codes[k] == `SBT_IR_SAMPLEZ);
            check("extest", extest_en, codes[k] == `SBT_IR_EXTEST);
            scan(1'h0, 32'hC35, 12, word);
            if (k < 4)
                check("pass", word[11:0], 12'h86A);
            else
            begin
                check("bscan", word[11:0], {4'hF, pin_levels});
                check("drive", bsr_drive, 8'h35);
            end
        end
        ctl.tick(1'h1, 1'h1, o);
        ctl.tick(1'h0, 1'h1, o);
        ctl.tick(1'h0, 1'h1, o);
        repeat (4) ctl.tick(1'h1, 1'h1, o);
        check("four_ones", tap_state, ST_SEL_IR);
        ctl.tick(1'h1, 1'h1, o);
        check("five_ones", tap_state, ST_RESET);
        check("tlr_instr", active_instr, `SBT_IR_IDCODE);
        wrap_up();
    end
endmodule
